// File: bench/bfs_bridge_model.sv
// behavioural half-bridge that watches the gate drives
`timescale 1ns/100ps

module bfs_bridge_model
(
    input wire logic ref_clk, // 25 MHz clock
    input wire logic highSideDrive, // high-side gate
    input wire logic lowSideDrive, // low-side gate
    output logic [15:0] lastPeriod, // cycles between high-side rises
    output logic [15:0] pulses, // high-side rises seen
    output logic shootThrough // both gates were on together
);
    // =====================================================================
    // pulse timing and shoot-through watch
    logic [15:0] perCnt;
    logic hsPrev;

    initial
    begin
        lastPeriod = '0;
        pulses = '0;
        shootThrough = 1'b0;
        perCnt = '0;
        hsPrev = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        // a shorted bridge is what the dead time must prevent
        if (highSideDrive === 1'b1 && lowSideDrive === 1'b1)
            shootThrough <= 1'b1;
        hsPrev <= highSideDrive;
        if (highSideDrive === 1'b1 && hsPrev === 1'b0)
        begin
            lastPeriod <= perCnt + 16'h0001;
            pulses <= pulses + 16'h0001;
            perCnt <= '0;
        end
        else
            perCnt <= perCnt + 16'h0001;
    end
endmodule // bfs_bridge_model

// File: bench/bfs_supervisor_tb_top.sv
// self-checking bench of the buck fault supervisor
`timescale 1ns/100ps
`define BFS_CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end

module bfs_supervisor_tb_top
    import bfs_pkg::*;
;
    // =====================================================================
    // signals and instances
    localparam int OC = 8;
    localparam int VQ = 4;
    localparam int PER = 16;
    logic ref_clk, rst_n, cyc, stb, we, ack, hs, ls, shoot;
    logic [3:0] adr, sel;
    logic [31:0] dat, rdat;
    logic [15:0] lastPeriod, pulses, p;
    logic [7:0] onT;
    logic [32:0] expQ[$];
    logic [32:0] ex;
    bfs_sense_t sense;
    bfs_pg_t pg;
    int mismatches = 0;
    int compares = 0;
    int seed = 51;

    bfs_supervisor #(.OC_CYC(OC), .VOLT_CYC(VQ), .PERIOD_CYC(PER)) i_bfs_supervisor (
        .ref_clk(ref_clk), .rst_n(rst_n), .senseIn(sense), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .highSideDrive(hs), .lowSideDrive(ls), .powerGoodOut(pg));

    bfs_bridge_model i_bfs_bridge_model (.ref_clk(ref_clk), .highSideDrive(hs),
        .lowSideDrive(ls), .lastPeriod(lastPeriod), .pulses(pulses), .shootThrough(shoot));

    // =====================================================================
    // tasks
    task end_of_test;
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        n = 0;
        expQ.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        @(posedge ref_clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20)
        begin
            mismatches++;
            end_of_test();
        end
        else
        begin
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {1'b0, e});
    endtask

    // =====================================================================
    // clock, watchdog and read-data watcher
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        tick(30000);
        mismatches++;
        end_of_test();
    end

    always @(posedge ref_clk)
    begin
        if (ack === 1'b1 && expQ.size() > 0)
        begin
            ex = expQ.pop_front();
            if (ex[32] === 1'b0)
                `BFS_CHK(rdat, ex[31:0])
        end
    end

    // =====================================================================
    // main sequence
    initial
    begin
        sense = '0;
        {cyc, stb, we, adr, sel, dat} = '0;
        rst_n = 1'b0;
        tick(12);
        rst_n <= 1'b1;
        sense.supplyOk <= 1'b1;
        sense.enableHigh <= 1'b1;
        tick(4);
        rd(4'h4, 32'h80);
        onT = 8'h02 + 8'($random(seed) & 3);
        bus(1'b1, 4'h0, {16'h0, onT, 8'h01}, {1'b1, 32'h0});
        rd(4'h0, {16'h0, onT, 8'h01});
        rd(4'h8, 32'h0);
        tick(60);
        `BFS_CHK(lastPeriod, 16'(PER))
        // falling output: on phase held, high side stays on
        sense.outFalling <= 1'b1;
        tick(10);
        p = pulses;
        tick(20);
        `BFS_CHK(pulses, p)
        `BFS_CHK({hs, ls}, 2'b10)
        sense.outFalling <= 1'b0;
        tick(2);
        // rising output: on phase cut, low side stays on
        sense.outRising <= 1'b1;
        tick(20);
        p = pulses;
        tick(20);
        `BFS_CHK(pulses, p)
        `BFS_CHK({hs, ls}, 2'b01)
        sense.outRising <= 1'b0;
        tick(50);
        `BFS_CHK(lastPeriod, 16'(PER))
        // two sub-threshold bursts must not add up
        sense.currentLimitSense <= 1'b1;
        tick(OC);
        sense.currentLimitSense <= 1'b0;
        tick(2);
        sense.currentLimitSense <= 1'b1;
        tick(OC);
        sense.currentLimitSense <= 1'b0;
        tick(10);
        rd(4'h4, 32'h80);
        sense.currentLimitSense <= 1'b1;
        tick(OC + 12);
        rd(4'h4, 32'h341);
        `BFS_CHK(pg, PG_PD35)
        `BFS_CHK({hs, ls}, 2'b00)
        sense.feedbackBelowUv <= 1'b1;
        tick(VQ + 12);
        rd(4'h4, 32'h345);
        sense.currentLimitSense <= 1'b0;
        sense.feedbackBelowUv <= 1'b0;
        tick(6);
        rd(4'h4, 32'h345);
        sense.enableHigh <= 1'b0;
        tick(6);
        rd(4'h4, 32'h180);
        sense.enableHigh <= 1'b1;
        tick(6);
        rd(4'h4, 32'h80);
        sense.feedbackAboveOvRise <= 1'b1;
        tick(VQ + 12);
        rd(4'h4, 32'h172);
        `BFS_CHK(pg, PG_PD65)
        `BFS_CHK(ls, 1'b1)
        sense.feedbackAboveOvRise <= 1'b0;
        sense.feedbackBelowOvFall <= 1'b1;
        tick(VQ + 12);
        rd(4'h4, 32'h162);
        `BFS_CHK(ls, 1'b0)
        sense.feedbackBelowOvFall <= 1'b0;
        sense.feedbackAboveOvRise <= 1'b1;
        tick(VQ + 12);
        `BFS_CHK(ls, 1'b1)
        sense.feedbackAboveOvRise <= 1'b0;
        sense.feedbackBelowOvFall <= 1'b1;
        sense.enableHigh <= 1'b0;
        tick(VQ + 12);
        rd(4'h4, 32'h162);
        sense.enableHigh <= 1'b1;
        sense.supplyOk <= 1'b0;
        tick(6);
        rd(4'h4, 32'h0);
        `BFS_CHK(pg, PG_UNDEF)
        sense.supplyOk <= 1'b1;
        sense.feedbackBelowOvFall <= 1'b0;
        tick(6);
        rd(4'h4, 32'h80);
        sense.tempHigh <= 1'b1;
        tick(10);
        p = pulses;
        tick(40);
        `BFS_CHK(pulses, p)
        `BFS_CHK({hs, ls}, 2'b00)
        rd(4'h4, 32'h88);
        sense.tempHigh <= 1'b0;
        tick(40);
        `BFS_CHK(pulses > p, 1'b1)
        rd(4'h4, 32'h80);
        sense.tempHigh <= 1'b1;
        tick(6);
        sense.feedbackBelowUv <= 1'b1;
        tick(VQ + 12);
        rd(4'h4, 32'h1AC);
        `BFS_CHK(pg, PG_PD95)
        sense.feedbackBelowUv <= 1'b0;
        sense.enableHigh <= 1'b0;
        tick(6);
        rd(4'h4, 32'h180);
        `BFS_CHK(shoot, 1'b0)
        end_of_test();
    end
endmodule // bfs_supervisor_tb_top

// File: inc/bfs_params.svh
// constants of the buck fault supervisor: timing, offsets, field positions, reset values
// Summary of operation
// - overcurrent qualifies after over 10 us, latches off
// - overcurrent fault: power good to 35 ohm
// - overcurrent clears on enable low or supply reset
// - overvoltage qualifies after above rise threshold 2 us
// - overvoltage fault: power good to 65 ohm
// - overvoltage clears only on supply reset
// - overvoltage latch: low side on above rise threshold
// - low side off below fall threshold 2 us
// - undervoltage qualifies after below threshold 2 us
// - undervoltage fault: power good to 95 ohm
// - undervoltage clears on enable low or supply reset
// - over temperature suspends switching, both drives low except the low side held by the overvoltage latch
// - over temperature changes no power good, no latch
// - switching resumes when temperature flag drops
// - enable low or supply reset ends over temperature
// - fault detection stays active during over temperature
// - steady switching at nominal 300 kHz
// - falling output stretches on time, cuts off time
// - rising output cuts on time, stretches off time
// - power good undefined while supply below reset
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH

// =====================================================================
// timing
`define BFS_CLK_HZ 25000000
`define BFS_CLK_MHZ 25
`define BFS_OC_TIME_NS 10000
`define BFS_VOLT_TIME_NS 2000
`define BFS_SW_FREQ_HZ 300000
`define BFS_OC_CYC ((`BFS_OC_TIME_NS * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_VOLT_CYC ((`BFS_VOLT_TIME_NS * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_PERIOD_CYC (`BFS_CLK_HZ / `BFS_SW_FREQ_HZ)

// =====================================================================
// register map
`define BFS_CTRL_ADDR 4'h0
`define BFS_STATUS_ADDR 4'h4
`define BFS_CTRL_RUN_BIT 0
`define BFS_CTRL_ON_LSB 8
`define BFS_ON_TIME_RST 8'h1C

`endif

// File: inc/bfs_pkg.sv
// types of the buck fault supervisor
package bfs_pkg;

    // comparator and pin levels from the analog side
    typedef struct packed {
        logic supplyOk;     // supply above power-on-reset threshold
        logic enableHigh;   // enable above its threshold
        logic tempHigh;     // over-temperature flag
        logic outRising;    // output rising during transient
        logic outFalling;   // output falling during transient
        logic feedbackBelowUv;    // feedback under uv_threshold
        logic feedbackBelowOvFall; // feedback under ov_fall_threshold
        logic feedbackAboveOvRise; // feedback over ov_rise_threshold
        logic currentLimitSense; // sense above current limit
    } bfs_sense_t;

    // power good pull-down level
    typedef enum logic [2:0] {
        PG_UNDEF = 3'h0,
        PG_RELEASED = 3'h1,
        PG_PD95 = 3'h3,
        PG_PD65 = 3'h2,
        PG_PD35 = 3'h6
    } bfs_pg_t;

    // which fault owns power good
    typedef enum logic [1:0] {
        FIRST_NONE = 2'h0,
        FIRST_UV = 2'h1,
        FIRST_OV = 2'h3,
        FIRST_OC = 2'h2
    } bfs_first_t;

endpackage

// File: rtl/bfs_supervisor.sv
// fault supervisor and gate-drive sequencing of a synchronous buck controller
`timescale 1ns/100ps
`include "bfs_params.svh"

module bfs_supervisor
    import bfs_pkg::*;
#(
    parameter int OC_CYC = `BFS_OC_CYC,
    parameter int VOLT_CYC = `BFS_VOLT_CYC,
    parameter int PERIOD_CYC = `BFS_PERIOD_CYC
)
(
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst_n, // async reset
    input wire bfs_sense_t senseIn, // comparators and pins
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write
    input wire logic [3:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic highSideDrive, // high_side_drive
    output logic lowSideDrive, // low_side_drive
    output bfs_pg_t powerGoodOut // power_good_out level
);

    localparam int NQ = 4;
    localparam int CW = 10;

    if (OC_CYC < 1 || OC_CYC > 1000 || VOLT_CYC < 1 || VOLT_CYC > 1000)
    begin : gBadQual
        $error("qualify counts out of range");
    end
    if (PERIOD_CYC < 4 || PERIOD_CYC > 255)
    begin : gBadPeriod
        $error("switching period out of range");
    end

    // =====================================================================
    // input synchronisers
    bfs_sense_t syncA_q;
    bfs_sense_t sense_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_q <= '0;
            sense_q <= '0;
        end
        else
        begin
            syncA_q <= senseIn;
            sense_q <= syncA_q;
        end
    end

    logic porOk;
    logic enOk;
    assign porOk = sense_q.supplyOk;
    assign enOk = sense_q.enableHigh;

    // =====================================================================
    // qualify counters: 0 current, 1 ov rise, 2 ov fall, 3 uv
    logic [NQ-1:0] qCond;
    logic [NQ-1:0] qual;
    assign qCond = {sense_q.feedbackBelowUv, sense_q.feedbackBelowOvFall,
                    sense_q.feedbackAboveOvRise, sense_q.currentLimitSense};

    function automatic logic [CW-1:0] qLimit(input int idx);
        qLimit = (idx == 0) ? CW'(OC_CYC) : CW'(VOLT_CYC);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi++)
        begin : gQual
            logic [CW-1:0] cnt_q;
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_q <= '0;
                else if (!qCond[gi])
                    cnt_q <= '0;
                else if (cnt_q != qLimit(gi))
                    cnt_q <= cnt_q + CW'(1);
            end
            // holds more than the limit once counter is full and still high
            assign qual[gi] = qCond[gi] && (cnt_q == qLimit(gi));
        end
    endgenerate

    // =====================================================================
    // fault latches
    logic ocFault_q;
    logic ovFault_q;
    logic uvFault_q;
    logic anyFault;
    assign anyFault = ocFault_q | ovFault_q | uvFault_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ocFault_q <= 1'b0;
            uvFault_q <= 1'b0;
        end
        else if (!porOk || !enOk)
        begin
            ocFault_q <= 1'b0;
            uvFault_q <= 1'b0;
        end
        else
        begin
            if (qual[0])
                ocFault_q <= 1'b1;
            if (qual[3])
                uvFault_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ovFault_q <= 1'b0;
        else if (!porOk)
            ovFault_q <= 1'b0;
        else if (enOk && qual[1])
            ovFault_q <= 1'b1;
    end

    // first fault keeps power good; on its clear the next survivor takes over
    bfs_first_t first_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            first_q <= FIRST_NONE;
        else
        begin
            unique case (first_q)
                FIRST_NONE:
                    if (ocFault_q)
                        first_q <= FIRST_OC;
                    else if (ovFault_q)
                        first_q <= FIRST_OV;
                    else if (uvFault_q)
                        first_q <= FIRST_UV;
                FIRST_OC:
                    if (!ocFault_q)
                        first_q <= ovFault_q ? FIRST_OV : FIRST_NONE;
                FIRST_OV:
                    if (!ovFault_q)
                        first_q <= FIRST_NONE;
                FIRST_UV:
                    if (!uvFault_q)
                        first_q <= ovFault_q ? FIRST_OV : FIRST_NONE;
            endcase
        end
    end

    // =====================================================================
    // over-temperature and discharge
    logic otState_q;
    logic tempPrev_q;
    logic discharge_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            otState_q <= 1'b0;
            tempPrev_q <= 1'b0;
        end
        else
        begin
            tempPrev_q <= sense_q.tempHigh;
            if (!porOk || !enOk || !sense_q.tempHigh)
                otState_q <= 1'b0;
            else if (!tempPrev_q)
                otState_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            discharge_q <= 1'b0;
        else if (!ovFault_q && !(enOk && porOk && qual[1]))
            discharge_q <= 1'b0;
        else if (qual[1])
            discharge_q <= 1'b1;
        else if (qual[2])
            discharge_q <= 1'b0;
    end

    // =====================================================================
    // registers
    logic runEnable_q;
    logic [7:0] onTime_q;
    logic busHit;
    assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            runEnable_q <= 1'b0;
            onTime_q <= `BFS_ON_TIME_RST;
        end
        else if (busHit && wb_we_i && wb_adr_i == `BFS_CTRL_ADDR)
        begin
            if (wb_sel_i[0])
                runEnable_q <= wb_dat_i[`BFS_CTRL_RUN_BIT];
            if (wb_sel_i[1])
                onTime_q <= wb_dat_i[`BFS_CTRL_ON_LSB +: 8];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= busHit;
            if (busHit && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    `BFS_CTRL_ADDR:
                        wb_dat_o <= {16'h0000, onTime_q, 7'h00, runEnable_q};
                    `BFS_STATUS_ADDR:
                        wb_dat_o <= {22'h000000, powerGoodOut, first_q,
                                     discharge_q, otState_q, uvFault_q, ovFault_q,
                                     ocFault_q};
                    default:
                        wb_dat_o <= '0;
                endcase
            end
        end
    end

    // =====================================================================
    // modulator timing
    logic [7:0] phase_q;
    logic onPhase;
    logic runOk;
    assign onPhase = phase_q < onTime_q;
    assign runOk = porOk && enOk && runEnable_q && !anyFault && !otState_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= '0;
        else if (!runOk || phase_q >= 8'(PERIOD_CYC - 1))
            phase_q <= '0;
        else if (onPhase && sense_q.outFalling)
            phase_q <= phase_q;
        else if (!onPhase && sense_q.outFalling)
            phase_q <= '0;
        else if (onPhase && sense_q.outRising)
            phase_q <= onTime_q;
        else if (!onPhase && sense_q.outRising)
            phase_q <= phase_q;
        else
            phase_q <= phase_q + 8'h01;
    end

    // =====================================================================
    // gate drives and power good
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            highSideDrive <= 1'b0;
            lowSideDrive <= 1'b0;
        end
        else
        begin
            highSideDrive <= runOk && onPhase && !lowSideDrive;
            if (ovFault_q)
                lowSideDrive <= discharge_q;
            else
                lowSideDrive <= runOk && !onPhase && !highSideDrive;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            powerGoodOut <= PG_UNDEF;
        else if (!porOk)
            powerGoodOut <= PG_UNDEF;
        else
        begin
            unique case (first_q)
                FIRST_OC: powerGoodOut <= PG_PD35;
                FIRST_OV: powerGoodOut <= PG_PD65;
                FIRST_UV: powerGoodOut <= PG_PD95;
                FIRST_NONE: powerGoodOut <= enOk ? PG_RELEASED : PG_PD95;
            endcase
        end
    end

    // =====================================================================
    // checks
    property p_ocLatch;
        @(posedge ref_clk) disable iff (!rst_n)
        (qual[0] && porOk && enOk) |=> ocFault_q;
    endproperty
    a_ocLatch: assert property (p_ocLatch) else $error("overcurrent not latched");

    property p_ocCause;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(ocFault_q) |-> $past(qual[0]) && $past(gQual[0].cnt_q) == CW'(OC_CYC);
    endproperty
    a_ocCause: assert property (p_ocCause) else $error("overcurrent latched early");

    property p_pg35;
        @(posedge ref_clk) disable iff (!rst_n)
        (first_q == FIRST_OC && porOk) |=> powerGoodOut == PG_PD35;
    endproperty
    a_pg35: assert property (p_pg35) else $error("power good not 35 ohm");

    property p_ovHold;
        @(posedge ref_clk) disable iff (!rst_n)
        (ovFault_q && porOk && !enOk) |=> ovFault_q;
    endproperty
    a_ovHold: assert property (p_ovHold) else $error("ov cleared by enable");

    property p_enClear;
        @(posedge ref_clk) disable iff (!rst_n)
        !enOk |=> !ocFault_q && !uvFault_q && !otState_q;
    endproperty
    a_enClear: assert property (p_enClear) else $error("enable low did not clear");

    property p_otGates;
        @(posedge ref_clk) disable iff (!rst_n)
        (otState_q && !ovFault_q) |=> !highSideDrive && !lowSideDrive;
    endproperty
    a_otGates: assert property (p_otGates) else $error("drives active in over-temp");

    property p_otNoLatch;
        @(posedge ref_clk) disable iff (!rst_n)
        ($rose(otState_q) && !anyFault && qual == '0) |=> !anyFault;
    endproperty
    a_otNoLatch: assert property (p_otNoLatch) else $error("over-temp latched off");

    property p_dischOn;
        @(posedge ref_clk) disable iff (!rst_n)
        (ovFault_q && qual[1] && porOk) |=> ##1 lowSideDrive;
    endproperty
    a_dischOn: assert property (p_dischOn) else $error("discharge not on");

    property p_dischOff;
        @(posedge ref_clk) disable iff (!rst_n)
        (ovFault_q && qual[2] && !qual[1] && porOk) ##1 ovFault_q |=> !lowSideDrive;
    endproperty
    a_dischOff: assert property (p_dischOff) else $error("discharge not off");

endmodule // bfs_supervisor
